// ===== hw/dmsc_dev.sv
// Device end: two-wire slave and three-wire write port of the control registers.
`timescale 1ns/100ps
`default_nettype none
`include "dmsc_regs.svh"
module dmsc_dev
   import dmsc_pkg::*;
#(
   parameter logic [5:0] ADDR_HI6 = `DMSC_ADDR_HI6
) (
   // Clock and reset
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RST,
   // Mode strap
   input  wire logic        I_MODE,
   // Serial link
   dmsc_link_if.dev         LINK,
   // Register file side
   output logic             O_WR_STROBE,
   output logic [15:0]      O_WR_ADDR,
   output logic [15:0]      O_WR_DATA,
   output logic             O_CLEAR_ALL,
   output logic [15:0]      O_RD_ADDR,
   input  wire logic [15:0] I_RD_DATA,
   // Status
   output logic             O_BUSY
);
   logic [2:0]  scl_q;
   logic [2:0]  sda_q;
   logic [2:0]  sel_q;
   logic [1:0]  mode_q;
   dmsc_slv_e   state;
   dmsc_ph_e    phase;
   logic [7:0]  shreg;
   logic [3:0]  bitcnt;
   logic        rw;
   logic [15:0] reg_addr;
   logic [7:0]  data_hi;
   logic [15:0] tx_word;
   logic        tx_lo;
   logic        sda_rel;
   logic [31:0] spi_word;

   wire       scl_h     = scl_q[1];
   wire       sda_h     = sda_q[1];
   wire       i2c_on    = mode_q[1];
   wire       start     = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
   wire       stop      = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
   wire       scl_rise  = scl_h & ~scl_q[2];
   wire       scl_fall  = ~scl_h & scl_q[2];
   wire [6:0] my_addr   = {ADDR_HI6, sel_q[1]};
   wire       addr_hit  = shreg[7:1] == my_addr;
   wire       byte_done = (state == S_RX) && scl_fall && (bitcnt == 4'h8);
   wire       quiet     = i2c_on && !stop && !start;
   wire       wr_i2c    = quiet && byte_done && (phase == PH_DL);
   wire       spi_latch = sel_q[1] & ~sel_q[2] & ~i2c_on;
   wire       wr_any    = wr_i2c | spi_latch;
   wire [15:0] wr_addr  = spi_latch ? spi_word[31:16] : reg_addr;
   wire [15:0] wr_data  = spi_latch ? spi_word[15:0] : {data_hi, shreg};

   // Device never drives the clock and only ever pulls data low.
   assign LINK.d_sda_o    = 1'b0;
   assign LINK.d_sda_oe_n = sda_rel;
   assign O_RD_ADDR       = reg_addr;

   function automatic dmsc_ph_e next_ph(input dmsc_ph_e p);
      case (p)
         PH_DEV:  next_ph = PH_AH;
         PH_AH:   next_ph = PH_AL;
         PH_AL:   next_ph = PH_DH;
         PH_DH:   next_ph = PH_DL;
         default: next_ph = PH_DH;
      endcase
   endfunction : next_ph

   // Pin synchronisers; stage 0 feeds only stage 1, stage 2 serves edge detection.
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         scl_q  <= 3'h7;
         sda_q  <= 3'h7;
         sel_q  <= 3'h7;
         mode_q <= 2'h3;
      end else begin
         scl_q  <= {scl_q[1:0], LINK.scl};
         sda_q  <= {sda_q[1:0], LINK.sda};
         sel_q  <= {sel_q[1:0], LINK.sel};
         mode_q <= {mode_q[0], I_MODE};
      end
   end

   // Link domain shift register. It only moves on clock edges, so a stopped
   // clock simply freezes the frame where it was.
   always_ff @(posedge LINK.scl or posedge I_RST) begin
      if (I_RST) begin
         spi_word <= 32'h0000_0000;
      end else if (!LINK.sel) begin
         spi_word <= {spi_word[30:0], LINK.sda};
      end
   end

   // Two-wire slave sequencer.
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         state    <= S_IDLE;
         phase    <= PH_DEV;
         shreg    <= 8'h00;
         bitcnt   <= 4'h0;
         rw       <= 1'b0;
         reg_addr <= 16'h0000;
         data_hi  <= 8'h00;
         tx_word  <= 16'h0000;
         tx_lo    <= 1'b0;
         sda_rel  <= 1'b1;
      end else if (!i2c_on || stop) begin
         state   <= S_IDLE;
         sda_rel <= 1'b1;
      end else if (start) begin
         state   <= S_RX;
         phase   <= PH_DEV;
         bitcnt  <= 4'h0;
         sda_rel <= 1'b1;
      end else begin
         case (state)
            S_RX: begin
               if (scl_rise && bitcnt != 4'h8) begin
                  shreg  <= {shreg[6:0], sda_h};
                  bitcnt <= bitcnt + 4'h1;
               end else if (byte_done) begin
                  if (phase == PH_DEV && !addr_hit) begin
                     state <= S_IDLE;
                  end else begin
                     state   <= S_RACK;
                     sda_rel <= 1'b0;
                     case (phase)
                        PH_DEV:  rw <= shreg[0];
                        PH_AH:   reg_addr[15:8] <= shreg;
                        PH_AL:   reg_addr[7:0] <= shreg;
                        PH_DH:   data_hi <= shreg;
                        default: reg_addr <= reg_addr + 16'h0001;
                     endcase
                  end
               end
            end
            S_RACK: begin
               if (scl_fall) begin
                  bitcnt <= 4'h0;
                  if (phase == PH_DEV && rw) begin
                     state   <= S_TX;
                     shreg   <= I_RD_DATA[15:8];
                     tx_word <= I_RD_DATA;
                     tx_lo   <= 1'b0;
                     sda_rel <= I_RD_DATA[15];
                  end else begin
                     state   <= S_RX;
                     phase   <= next_ph(phase);
                     sda_rel <= 1'b1;
                  end
               end
            end
            S_TX: begin
               if (scl_fall) begin
                  if (bitcnt == 4'h7) begin
                     state   <= S_MACK;
                     sda_rel <= 1'b1;
                  end else begin
                     bitcnt  <= bitcnt + 4'h1;
                     shreg   <= {shreg[6:0], 1'b0};
                     sda_rel <= shreg[6];
                  end
               end
            end
            S_MACK: begin
               if (scl_rise && sda_h) begin
                  state <= S_IDLE;
               end else if (scl_fall) begin
                  state  <= S_TX;
                  bitcnt <= 4'h0;
                  if (!tx_lo) begin
                     shreg    <= tx_word[7:0];
                     sda_rel  <= tx_word[7];
                     tx_lo    <= 1'b1;
                     reg_addr <= reg_addr + 16'h0001;
                  end else begin
                     shreg   <= I_RD_DATA[15:8];
                     tx_word <= I_RD_DATA;
                     sda_rel <= I_RD_DATA[15];
                     tx_lo   <= 1'b0;
                  end
               end
            end
            default: begin
               state   <= S_IDLE;
               sda_rel <= 1'b1;
            end
         endcase
      end
   end

   // Register write port; the three-wire word is stable once select is high,
   // so it is read here only under the synchronised select edge.
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         O_WR_STROBE <= 1'b0;
         O_WR_ADDR   <= 16'h0000;
         O_WR_DATA   <= 16'h0000;
         O_CLEAR_ALL <= 1'b0;
         O_BUSY      <= 1'b0;
      end else begin
         O_WR_STROBE <= wr_any;
         O_CLEAR_ALL <= wr_any && (wr_addr == `DMSC_CLR_ADDR);
         O_BUSY      <= (state != S_IDLE) || !sel_q[1] && !i2c_on;
         if (wr_any) begin
            O_WR_ADDR <= wr_addr;
            O_WR_DATA <= wr_data;
         end
      end
   end
endmodule : dmsc_dev
`default_nettype wire

// ===== hw/dmsc_regs.svh
// Constants for the dual mode serial control port.
// How it works
// - Two-wire device is slave only, never drives clock
// - Transactions open with START; master sends, slave detects
// - STOP returns the slave to idle standby
// - Ninth clock: receiver pulls data low to acknowledge
// - Address byte: seven address bits plus direction bit
// - Slave acknowledges only its own address
// - Own address 0x1C or 0x1D from select pin
// - Write: address, register address, data bytes, STOP
// - Read: write register address, repeated START, read
// - Read returns sixteen-bit register as two bytes
// - Master acks; slave auto-increments and continues
// - Read index wraps from 0xFFFF to 0x0000
// - Read data continues until the master's not-acknowledge
// - Mode pin low selects three-wire write mode
// - Three-wire frame: 16-bit address, 16-bit data
// - Shift data on rising clock until select rises
// - Select rising edge writes last 32 bits
// - Static clock; transfers resume after any pause
// - Write to address zero restores all defaults
`ifndef DMSC_REGS_SVH
`define DMSC_REGS_SVH
`define DMSC_ADDR_HI6      6'h0E
`define DMSC_CLR_ADDR      16'h0000
`define DMSC_SPI_BITS      32
`define DMSC_CLK_SYS_NS    5
`define DMSC_SCL_PERIOD_NS 10000
`define DMSC_QUARTER_CYC   (`DMSC_SCL_PERIOD_NS / (4 * `DMSC_CLK_SYS_NS))
`endif

// ===== hw/dmsc_pkg.sv
// Types shared by both ends of the serial control port.
package dmsc_pkg;
   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_RX = 3'h1, S_RACK = 3'h3, S_TX = 3'h2, S_MACK = 3'h6
   } dmsc_slv_e;
   typedef enum logic [2:0] {
      PH_DEV = 3'h0, PH_AH = 3'h1, PH_AL = 3'h3, PH_DH = 3'h2, PH_DL = 3'h6
   } dmsc_ph_e;
   typedef enum logic [2:0] {
      H_IDLE = 3'h0, H_START = 3'h1, H_BIT = 3'h3, H_STOP = 3'h2,
      H_SPI = 3'h6, H_SPI_END = 3'h7
   } dmsc_host_e;
   typedef enum logic [1:0] {
      CMD_I2C_WR = 2'h0, CMD_I2C_RD = 2'h1, CMD_SPI_WR = 2'h2
   } dmsc_cmd_e;
endpackage : dmsc_pkg

// ===== hw/dmsc_link_if.sv
// Pins between the host controller and the control port.
`timescale 1ns/100ps
`default_nettype none
interface dmsc_link_if;
   logic scl;
   logic sel;
   logic h_sda_o;
   logic h_sda_oe_n;
   logic d_sda_o;
   logic d_sda_oe_n;
   wire  sda;
   // Pulled-up line; any enabled driver showing low pulls it low.
   assign sda = ~((~h_sda_oe_n & ~h_sda_o) | (~d_sda_oe_n & ~d_sda_o));
   modport dev  (input scl, sel, sda, output d_sda_o, d_sda_oe_n);
   modport host (output scl, sel, h_sda_o, h_sda_oe_n, input sda);
endinterface : dmsc_link_if
`default_nettype wire

// ===== hw/dmsc_host.sv
// Host end: serial bus master that issues register writes and reads.
`timescale 1ns/100ps
`default_nettype none
`include "dmsc_regs.svh"
module dmsc_host
   import dmsc_pkg::*;
#(
   parameter int QUARTER_CYC = `DMSC_QUARTER_CYC
) (
   // Clock and reset
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RST,
   // Command
   input  wire logic        I_CMD_VALID,
   input  wire dmsc_cmd_e   I_CMD_KIND,
   input  wire logic [6:0]  I_CMD_DEV,
   input  wire logic [15:0] I_CMD_REG,
   input  wire logic [15:0] I_CMD_DATA,
   input  wire logic [3:0]  I_CMD_NREG,
   input  wire logic        I_SEL_LEVEL,
   output logic             O_CMD_READY,
   // Answer
   output logic             O_RD_VALID,
   output logic [15:0]      O_RD_DATA,
   output logic             O_NACK,
   // Serial link
   dmsc_link_if.host        LINK
);
   dmsc_host_e  state;
   logic [15:0] div;
   logic [1:0]  q;
   logic [5:0]  bitn;
   logic [5:0]  bi;
   dmsc_cmd_e   kind;
   logic [6:0]  dev;
   logic [15:0] raddr;
   logic [31:0] word;
   logic [3:0]  nreg;
   logic [15:0] rx;
   logic        ack_bit;
   logic [1:0]  sda_q;
   logic        scl_r;
   logic        sel_r;
   logic        sda_o;
   logic        oe_n;

   wire       tick    = div == 16'(QUARTER_CYC - 1);
   wire [5:0] last_bi = {1'b0, nreg, 1'b0} + 6'h05;
   wire       rcv     = (kind == CMD_I2C_RD) && (bi >= 6'h04);
   wire       last_rx = bi == last_bi;
   wire [7:0] cur_byte = (bi == 6'h00) ? {dev, 1'b0} :
                         (bi == 6'h01) ? raddr[15:8] :
                         (bi == 6'h02) ? raddr[7:0] :
                         (bi == 6'h03) ? ((kind == CMD_I2C_RD) ? {dev, 1'b1} : word[15:8]) :
                         word[7:0];
   wire       send_bit = (bitn == 6'h08) ? (rcv ? last_rx : 1'b1) :
                         (rcv ? 1'b1 : cur_byte[3'(7 - bitn)]);
   wire       seq_end  = (kind == CMD_I2C_WR && bi == 6'h04) || (rcv && last_rx);

   assign LINK.scl        = scl_r;
   assign LINK.sel        = sel_r;
   assign LINK.h_sda_o    = sda_o;
   assign LINK.h_sda_oe_n = oe_n;

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         sda_q <= 2'h3;
         div   <= 16'h0000;
      end else begin
         sda_q <= {sda_q[0], LINK.sda};
         div   <= (tick || state == H_IDLE) ? 16'h0000 : div + 16'h0001;
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         state <= H_IDLE;
         q <= 2'h0;
         bitn <= 6'h00;
         bi <= 6'h00;
         kind <= CMD_I2C_WR;
         dev <= 7'h00;
         raddr <= 16'h0000;
         word <= 32'h0000_0000;
         nreg <= 4'h0;
         rx <= 16'h0000;
         ack_bit <= 1'b1;
         scl_r <= 1'b1;
         sel_r <= 1'b1;
         sda_o <= 1'b0;
         oe_n <= 1'b1;
         O_CMD_READY <= 1'b0;
         O_RD_VALID <= 1'b0;
         O_RD_DATA <= 16'h0000;
         O_NACK <= 1'b0;
      end else begin
         O_RD_VALID  <= 1'b0;
         O_CMD_READY <= (state == H_IDLE) && !(I_CMD_VALID && O_CMD_READY);
         if (state == H_IDLE) begin
            sel_r <= I_SEL_LEVEL;
            if (I_CMD_VALID && O_CMD_READY) begin
               kind  <= I_CMD_KIND;
               dev   <= I_CMD_DEV;
               raddr <= I_CMD_REG;
               nreg  <= I_CMD_NREG;
               word  <= {I_CMD_REG, I_CMD_DATA};
               bi    <= 6'h00;
               bitn  <= 6'h00;
               q     <= 2'h0;
               O_NACK <= 1'b0;
               if (I_CMD_KIND == CMD_SPI_WR) begin
                  state <= H_SPI;
                  sel_r <= 1'b0;
               end else begin
                  state <= H_START;
               end
            end
         end else if (tick) begin
            q <= q + 2'h1;
            case (state)
               H_START: begin
                  // Release, raise the clock, then pull data low while it is high.
                  if (q == 2'h0) oe_n <= 1'b1;
                  if (q == 2'h1) scl_r <= 1'b1;
                  if (q == 2'h2) oe_n <= 1'b0;
                  if (q == 2'h3) begin
                     scl_r <= 1'b0;
                     state <= H_BIT;
                     bitn  <= 6'h00;
                  end
               end
               H_BIT: begin
                  if (q == 2'h0) oe_n <= send_bit;
                  if (q == 2'h1) scl_r <= 1'b1;
                  if (q == 2'h2 && bitn == 6'h08) ack_bit <= sda_q[1];
                  if (q == 2'h2 && bitn != 6'h08 && rcv) rx <= {rx[14:0], sda_q[1]};
                  if (q == 2'h3) begin
                     scl_r <= 1'b0;
                     bitn  <= bitn + 6'h01;
                     if (bitn == 6'h08) begin
                        bitn <= 6'h00;
                        bi   <= bi + 6'h01;
                        if (rcv && bi[0]) begin
                           O_RD_VALID <= 1'b1;
                           O_RD_DATA  <= rx;
                        end
                        if (!rcv && ack_bit) begin
                           O_NACK <= 1'b1;
                           state  <= H_STOP;
                        end else if (seq_end) begin
                           state <= H_STOP;
                        end else if (kind == CMD_I2C_RD && bi == 6'h02) begin
                           state <= H_START;
                        end
                     end
                  end
               end
               H_STOP: begin
                  if (q == 2'h0) oe_n <= 1'b0;
                  if (q == 2'h1) scl_r <= 1'b1;
                  if (q == 2'h2) oe_n <= 1'b1;
                  if (q == 2'h3) state <= H_IDLE;
               end
               H_SPI: begin
                  if (q == 2'h0) begin
                     scl_r <= 1'b0;
                     oe_n  <= 1'b0;
                     sda_o <= word[31];
                  end
                  if (q == 2'h2) scl_r <= 1'b1;
                  if (q == 2'h3) begin
                     word <= {word[30:0], 1'b0};
                     bitn <= bitn + 6'h01;
                     if (bitn == 6'(`DMSC_SPI_BITS - 1)) state <= H_SPI_END;
                  end
               end
               H_SPI_END: begin
                  if (q == 2'h1) sel_r <= 1'b1;
                  if (q == 2'h3) begin
                     oe_n  <= 1'b1;
                     sda_o <= 1'b0;
                     state <= H_IDLE;
                  end
               end
               default: state <= H_IDLE;
            endcase
         end
      end
   end
endmodule : dmsc_host
`default_nettype wire

// ===== testbench/dmsc_link_checker.sv
// Checker of the serial link pins between the host end and the device end.
`timescale 1ns/100ps
`default_nettype none
module dmsc_link_checker #(
   parameter logic [5:0] ADDR_HI6 = 6'h0E
) (
   // Clock and reset
   input  wire logic I_CLK_SYS,
   input  wire logic I_RST,
   // Mode strap, high for the two-wire slave.
   input  wire logic mode,
   // Link signals
   input  wire logic scl,
   input  wire logic sel,
   input  wire logic h_sda_o,
   input  wire logic h_sda_oe_n,
   input  wire logic d_sda_o,
   input  wire logic d_sda_oe_n,
   input  wire logic sda
);
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);
   logic       scl_q;
   logic       sda_q;
   logic       in_first;
   logic       miss;
   logic       idle;
   logic [3:0] cnt;
   logic [6:0] addr7;
   wire        start_seen = scl & scl_q & sda_q & ~sda;
   wire        stop_seen  = scl & scl_q & ~sda_q & sda;
   wire        rise       = scl & ~scl_q;
   wire        addr_ok    = (addr7 == {ADDR_HI6, sel});
   // Bus conditions are tracked on the sampled pins, so they trail the wire by one cycle.
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
         in_first <= 1'b0;
         miss     <= 1'b0;
         idle     <= 1'b1;
         cnt      <= 4'h0;
         addr7    <= 7'h00;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start_seen) begin
            in_first <= 1'b1;
            cnt      <= 4'h0;
            miss     <= 1'b0;
            idle     <= 1'b0;
         end else if (rise && in_first) begin
            cnt <= cnt + 4'h1;
            if (cnt < 4'h7) addr7 <= {addr7[5:0], sda};
            if (cnt == 4'h8) in_first <= 1'b0;
            // A three-wire device never answers, even when the address matches.
            if (cnt == 4'h8) miss <= ~(addr_ok && mode);
         end
         if (stop_seen) idle <= 1'b1;
      end
   end
   od_pull_only_a: assert property (!d_sda_oe_n |-> !d_sda_o)
      else $error("device drove the data line high");
   dev_sda_change_a: assert property ($changed(d_sda_oe_n) |-> !scl)
      else $error("device changed the data line while the clock was high");
   no_bus_clash_a: assert property (scl && !d_sda_oe_n |-> h_sda_oe_n)
      else $error("host and device drove the data line together");
   addr_byte_quiet_a: assert property (in_first && cnt < 4'h8 |-> d_sda_oe_n)
      else $error("device drove the line during an address byte");
   ack_on_match_a: assert property (rise && in_first && cnt == 4'h8 |-> !sda == (addr_ok && mode))
      else $error("address acknowledge does not follow the address match");
   miss_released_a: assert property (miss |-> d_sda_oe_n)
      else $error("device drove the line after an address mismatch");
   stop_idle_quiet_a: assert property (idle |-> d_sda_oe_n)
      else $error("device drove the line after a stop");
   spi_data_setup_a: assert property (!sel && !$past(sel) && $changed(h_sda_o) |-> !scl)
      else $error("frame data changed while the clock was high");
   spi_latch_edge_a: assert property ($rose(sel) |-> scl)
      else $error("select rose while the clock was low");
   cover property (start_seen);
   cover property (rise && in_first && cnt == 4'h8 && addr_ok);
   cover property (miss);
   cover property ($rose(sel));
endmodule : dmsc_link_checker
`default_nettype wire

// ===== testbench/dual_mode_serial_control_port_tb.sv
// Bench of the host end and the device end joined over the serial link.
`timescale 1ns/100ps
`default_nettype none
module dual_mode_serial_control_port_tb
   import dmsc_pkg::*;
   ;
   localparam logic [15:0] fill_key  = 16'hC3A5;
   localparam logic [20:0] miss_devs = {7'h1C, 7'h2D, 7'h5D};
   logic        clk = 1'b0;
   logic        rst;
   logic        mode;
   logic        cmd_valid;
   logic        sel_level;
   dmsc_cmd_e   cmd_kind;
   logic [6:0]  cmd_dev;
   logic [15:0] cmd_reg;
   logic [15:0] cmd_data;
   logic [3:0]  cmd_nreg;
   logic        ready;
   logic        rd_valid;
   logic        nack;
   logic        wr_strobe;
   logic        clear_all;
   logic        busy;
   logic [15:0] rd_data;
   logic [15:0] wr_addr;
   logic [15:0] wr_data;
   logic [15:0] rd_addr;
   logic [15:0] rd_mem;
   logic [15:0] cap_addr;
   logic [15:0] cap_data;
   logic [15:0] rd_q[$];
   int          bad_count;
   int          checks;
   int          n_wr;
   int          n_clr;
   dmsc_link_if link ();
   // The register file stands outside the block; a keyed pattern makes every index distinct.
   assign rd_mem = rd_addr ^ fill_key;
   always #2.5 clk = ~clk;
   dmsc_host #(.QUARTER_CYC(4)) i_dmsc_host (
      .I_CLK_SYS(clk), .I_RST(rst), .I_CMD_VALID(cmd_valid), .I_CMD_KIND(cmd_kind),
      .I_CMD_DEV(cmd_dev), .I_CMD_REG(cmd_reg), .I_CMD_DATA(cmd_data), .I_CMD_NREG(cmd_nreg),
      .I_SEL_LEVEL(sel_level), .O_CMD_READY(ready), .O_RD_VALID(rd_valid),
      .O_RD_DATA(rd_data), .O_NACK(nack), .LINK(link));
   dmsc_dev #(.ADDR_HI6(6'h0E)) i_dmsc_dev (
      .I_CLK_SYS(clk), .I_RST(rst), .I_MODE(mode), .LINK(link), .O_WR_STROBE(wr_strobe),
      .O_WR_ADDR(wr_addr), .O_WR_DATA(wr_data), .O_CLEAR_ALL(clear_all),
      .O_RD_ADDR(rd_addr), .I_RD_DATA(rd_mem), .O_BUSY(busy));
   dmsc_link_checker #(.ADDR_HI6(6'h0E)) i_dmsc_link_checker (
      .I_CLK_SYS(clk), .I_RST(rst), .mode(mode), .scl(link.scl), .sel(link.sel),
      .h_sda_o(link.h_sda_o), .h_sda_oe_n(link.h_sda_oe_n), .d_sda_o(link.d_sda_o),
      .d_sda_oe_n(link.d_sda_oe_n), .sda(link.sda));
   // Outputs are taken mid-cycle, well clear of the edge that launches them.
   always @(negedge clk) begin
      if (wr_strobe === 1'b1) begin
         n_wr++;
         cap_addr = wr_addr;
         cap_data = wr_data;
      end
      if (clear_all === 1'b1) n_clr++;
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("Mismatches %0d of %0d checks", bad_count, checks);
      if (bad_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task automatic run_cmd(input dmsc_cmd_e k, input logic [6:0] dv, input logic [15:0] rg,
                          input logic [15:0] dt, input logic [3:0] nr);
      int n;
      n_wr = 0;
      n_clr = 0;
      rd_q.delete();
      n = 0;
      @(negedge clk);
      cmd_kind = k;
      cmd_dev = dv;
      cmd_reg = rg;
      cmd_data = dt;
      cmd_nreg = nr;
      cmd_valid = 1'b1;
      while (ready !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      while (ready !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      check(n < 4000, 1, "command did not finish");
      // The register strobe trails the last pin event by a few synchroniser cycles.
      repeat (12) @(negedge clk);
   endtask : run_cmd
   task automatic t_write();
      sel_level = 1'b0;
      repeat (8) @(negedge clk);
      run_cmd(CMD_I2C_WR, 7'h1C, 16'h8001, 16'hBEEF, 4'h0);
      check(n_wr, 1, "write count");
      check(cap_addr, 16'h8001, "write address");
      check(cap_data, 16'hBEEF, "write data");
      check(nack, 0, "write acknowledge");
      check(n_clr, 0, "clear on plain write");
      check(busy, 0, "standby after stop");
      run_cmd(CMD_I2C_WR, 7'h1C, 16'h0000, 16'h1234, 4'h0);
      check(n_clr, 1, "clear on address zero");
   endtask : t_write
   task automatic t_read();
      int          i;
      logic [15:0] e;
      sel_level = 1'b1;
      repeat (8) @(negedge clk);
      run_cmd(CMD_I2C_RD, 7'h1D, 16'hFFFE, 16'h0000, 4'h2);
      check(rd_q.size(), 3, "read word count");
      for (i = 0; i < 3; i++) begin
         e = 16'hFFFE + 16'(i);
         check(rd_q[i], e ^ fill_key, "read word");
      end
      check(nack, 0, "read acknowledges");
      check(rd_addr, 16'h0001, "index after read");
   endtask : t_read
   task automatic t_miss();
      int i;
      for (i = 0; i < 3; i++) begin
         run_cmd(CMD_I2C_WR, miss_devs[i*7 +: 7], 16'h0040, 16'h9999, 4'h0);
         check(nack, 1, "foreign address acknowledged");
         check(n_wr, 0, "foreign write taken");
      end
   endtask : t_miss
   task automatic t_spi();
      mode = 1'b0;
      sel_level = 1'b1;
      repeat (8) @(negedge clk);
      run_cmd(CMD_SPI_WR, 7'h00, 16'hA55A, 16'h0F0F, 4'h0);
      check(n_wr, 1, "frame write count");
      check(cap_addr, 16'hA55A, "frame address");
      check(cap_data, 16'h0F0F, "frame data");
      run_cmd(CMD_I2C_WR, 7'h1D, 16'h0010, 16'h5555, 4'h0);
      check(n_wr, 0, "two-wire write in three-wire mode");
      check(nack, 1, "two-wire acknowledge in three-wire mode");
      mode = 1'b1;
      repeat (8) @(negedge clk);
      run_cmd(CMD_SPI_WR, 7'h00, 16'h0020, 16'h6666, 4'h0);
      check(n_wr, 0, "frame in two-wire mode");
      run_cmd(CMD_I2C_WR, 7'h1D, 16'h0030, 16'h7777, 4'h0);
      check(cap_data, 16'h7777, "two-wire write after return");
   endtask : t_spi
   // The tests need some 6000 cycles; the limit leaves a wide margin.
   initial begin
      #300000;
      bad_count++;
      stop_test();
   end
   initial begin
      rst = 1'b1;
      mode = 1'b1;
      cmd_valid = 1'b0;
      cmd_kind = CMD_I2C_WR;
      cmd_dev = 7'h00;
      cmd_reg = 16'h0000;
      cmd_data = 16'h0000;
      cmd_nreg = 4'h0;
      sel_level = 1'b0;
      bad_count = 0;
      checks = 0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      t_write();
      t_read();
      t_miss();
      t_spi();
      stop_test();
   end
endmodule : dual_mode_serial_control_port_tb
`default_nettype wire
